// ==== dmr_dbg_model.sv ====
`timescale 1ns/1ps
module dmr_dbg_model (
  input wire logic clk,
  output dmr_pkg::dmr_req_t req,
  input wire dmr_pkg::dmr_rsp_t rsp
);
  initial begin
    req = '0;
  end
  // one whole word per access, strobe held for one edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    req = '{sel: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req.sel = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0);
    d = rsp.rdata;
  endtask
endmodule

// ==== dmr_params.svh ====
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH
`define DMR_OFF_PRSR 12'h314
`define DMR_OFF_MAIN_ID 12'hd00
`define DMR_OFF_CACHE_TYPE 12'hd04
`define DMR_OFF_HOLE_D08 12'hd08
`define DMR_OFF_TLB_TYPE 12'hd0c
`define DMR_OFF_HOLE_D10 12'hd10
`define DMR_OFF_MP_AFF 12'hd14
`define DMR_OFF_MAIN_ALIAS0 12'hd18
`define DMR_OFF_MAIN_ALIAS1 12'hd1c
`define DMR_OFF_PFR0 12'hd20
`define DMR_OFF_PFR1 12'hd24
`define DMR_OFF_DFR0 12'hd28
`define DMR_OFF_AFR0 12'hd2c
`define DMR_OFF_MMFR0 12'hd30
`define DMR_OFF_MMFR1 12'hd34
`define DMR_OFF_MMFR2 12'hd38
`define DMR_OFF_MMFR3 12'hd3c
`define DMR_OFF_ISAR0 12'hd40
`define DMR_OFF_ISAR1 12'hd44
`define DMR_OFF_ISAR2 12'hd48
`define DMR_OFF_ISAR3 12'hd4c
`define DMR_OFF_ISAR4 12'hd50
`define DMR_OFF_ISAR5 12'hd54
`define DMR_OFF_ITCTRL 12'hf00
`define DMR_OFF_CLAIM_SET 12'hfa0
`define DMR_OFF_CLAIM_CLR 12'hfa4
`define DMR_OFF_LOCK_KEY 12'hfb0
`define DMR_OFF_LOCK_STATE 12'hfb4
`define DMR_OFF_AUTH 12'hfb8
`define DMR_OFF_UNIT_ID 12'hfc8
`define DMR_OFF_UNIT_TYPE 12'hfcc
`define DMR_OFF_IDENT_LO 12'hfd0
`define DMR_OFF_IDENT_HI 12'hffc
`define DMR_OFF_RSV_LO 12'hf04
`define DMR_OFF_RSV_HI 12'hf9c
`define DMR_OFF_RSV2_LO 12'hfbc
`define DMR_OFF_RSV2_HI 12'hfc4
`define DMR_OFF_RAZ_E_LO 12'he00
`define DMR_OFF_RAZ_E_HI 12'hef0
`define DMR_VAL_CACHE_TYPE 32'h83338003
`define DMR_VAL_TLB_TYPE 32'h00000000
`define DMR_VAL_PFR0 32'h00001231
`define DMR_VAL_PFR1 32'h00000011
`define DMR_VAL_DFR0 32'h02010444
`define DMR_VAL_MMFR0 32'h00100103
`define DMR_VAL_MMFR1 32'h40000000
`define DMR_VAL_MMFR2 32'h01230000
`define DMR_VAL_MMFR3 32'h00102211
`define DMR_VAL_ISAR0 32'h00101111
`define DMR_VAL_ISAR1 32'h13112111
`define DMR_VAL_ISAR2 32'h21232041
`define DMR_VAL_ISAR3 32'h11112131
`define DMR_VAL_ISAR4 32'h00011142
`define DMR_VAL_CLAIM_SET_RD 32'h000000ff
`define DMR_VAL_UNLOCK_KEY 32'hc5acce55
`define DMR_CLAIM_W 8
`define DMR_ITCTRL_RST 1'b0
`define DMR_CLAIM_RST 8'h00
`define DMR_LOCKED_RST 1'b1
`define DMR_PRSR_STICKY_RST 1'b0
`define DMR_PRSR_STICKY_BIT 3
`define DMR_PRSR_RESET_BIT 2
`define DMR_PRSR_SPD_BIT 1
`define DMR_PRSR_PWRUP_BIT 0
`define DMR_LSR_LOCKED_BIT 1
`define DMR_LSR_IMPL_BIT 0
`endif

// ==== dmr_pkg.sv ====
package dmr_pkg;
  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dmr_req_t;
  typedef struct packed {
    logic [31:0] rdata;
  } dmr_rsp_t;
  typedef struct packed {
    logic [31:0] main_id;
    logic [31:0] mp_affinity;
    logic [31:0] auth_state;
    logic [31:0] unit_id;
    logic [31:0] unit_type;
  } dmr_core_info_t;
endpackage

// ==== dmr_regs.sv ====
// What this block does
// - status register bits 31 to 4 read zero; writes there ignored
// - status bit 3 sticky reset, bit 2 live reset, bit 1 reads zero
// - status bit 0 powered-up always reads one
// - no power-down state reported; core is always treated as powered
// - offsets 0xd00 to 0xd54 are read-only copies of core id registers
// - each mirror returns the core's coprocessor register value exactly
// - cache type mirror at 0xd04 reads 0x83338003
// - tlb type at 0xd0c reads zero; 0xd08 and 0xd10 read zero
// - affinity at 0xd14 from core; 0xd18 and 0xd1c alias main id
// - feature mirrors 0xd20, 0xd24, 0xd28 read their fixed values
// - auxiliary feature slot at 0xd2c reads zero
// - memory model mirrors 0xd30 to 0xd3c read their fixed values
// - instruction set mirrors 0xd40 to 0xd50 fixed; 0xd54 reads zero
// - integration mode control at 0xf00 is readable and writable
// - offsets 0xf04 to 0xf9c read zero
// - claim set and claim clear registers are readable and writable
// - lock key at 0xfb0 write-only; lock state at 0xfb4 read-only
// - authentication state at 0xfb8 read-only; 0xfbc to 0xfc4 read zero
// - unit identifier, unit type and 0xfd0 to 0xffc are read-only
// - claim set writes one to set; reads 0xff; clear reads claim state
// - unlock key unlocks writes, any other value locks; locked writes ignored
`timescale 1ns/1ps
`include "dmr_params.svh"
module dmr_regs #(
  parameter int CLAIM_W = `DMR_CLAIM_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire dmr_pkg::dmr_req_t req,
  output dmr_pkg::dmr_rsp_t rsp,
  input wire dmr_pkg::dmr_core_info_t core_info,
  input wire logic [383:0] ident_regs,
  input wire logic core_in_reset,
  output logic integration_mode
);

  logic [CLAIM_W-1:0] claim_q;
  logic [CLAIM_W-1:0] claim_d;
  logic locked_q;
  logic itctrl_q;
  logic sticky_reset_q;
  logic reset_s1_q;
  logic reset_s2_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic wr;
  logic rd;
  logic wr_ok;
  logic [3:0] ident_idx;

  assign wr = req.sel && req.write;
  assign rd = req.sel && !req.write;
  // lock gates every write except the key itself
  assign wr_ok = wr && !locked_q;
  // identification words start at 0xfd0, so that offset is word zero
  assign ident_idx = req.addr[5:2] - 4'h4;

  // core reset arrives from another domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_s1_q <= 1'b0;
      reset_s2_q <= 1'b0;
    end else begin
      reset_s1_q <= core_in_reset;
      reset_s2_q <= reset_s1_q;
    end
  end

  // sticky reset set by core reset, cleared by a status read; set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sticky_reset_q <= `DMR_PRSR_STICKY_RST;
    end else if (reset_s2_q) begin
      sticky_reset_q <= 1'b1;
    end else if (rd && req.addr == `DMR_OFF_PRSR) begin
      sticky_reset_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      locked_q <= `DMR_LOCKED_RST;
    end else if (wr && req.addr == `DMR_OFF_LOCK_KEY) begin
      locked_q <= (req.wdata != `DMR_VAL_UNLOCK_KEY);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      itctrl_q <= `DMR_ITCTRL_RST;
    end else if (wr_ok && req.addr == `DMR_OFF_ITCTRL) begin
      itctrl_q <= req.wdata[0];
    end
  end
  assign integration_mode = itctrl_q;

  always_comb begin
    claim_d = claim_q;
    if (wr_ok && req.addr == `DMR_OFF_CLAIM_SET) begin
      claim_d = claim_q | req.wdata[CLAIM_W-1:0];
    end else if (wr_ok && req.addr == `DMR_OFF_CLAIM_CLR) begin
      claim_d = claim_q & ~req.wdata[CLAIM_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      claim_q <= CLAIM_W'(`DMR_CLAIM_RST);
    end else begin
      claim_q <= claim_d;
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    if (req.addr >= `DMR_OFF_IDENT_LO) begin
      rdata_d = ident_regs[32*ident_idx +: 32];
    end else begin
      unique case (req.addr)
        `DMR_OFF_PRSR: begin
          rdata_d[`DMR_PRSR_STICKY_BIT] = sticky_reset_q;
          rdata_d[`DMR_PRSR_RESET_BIT] = reset_s2_q;
          rdata_d[`DMR_PRSR_SPD_BIT] = 1'b0;
          rdata_d[`DMR_PRSR_PWRUP_BIT] = 1'b1;
        end
        `DMR_OFF_MAIN_ID: rdata_d = core_info.main_id;
        `DMR_OFF_CACHE_TYPE: rdata_d = `DMR_VAL_CACHE_TYPE;
        `DMR_OFF_TLB_TYPE: rdata_d = `DMR_VAL_TLB_TYPE;
        `DMR_OFF_MP_AFF: rdata_d = core_info.mp_affinity;
        `DMR_OFF_MAIN_ALIAS0: rdata_d = core_info.main_id;
        `DMR_OFF_MAIN_ALIAS1: rdata_d = core_info.main_id;
        `DMR_OFF_PFR0: rdata_d = `DMR_VAL_PFR0;
        `DMR_OFF_PFR1: rdata_d = `DMR_VAL_PFR1;
        `DMR_OFF_DFR0: rdata_d = `DMR_VAL_DFR0;
        `DMR_OFF_MMFR0: rdata_d = `DMR_VAL_MMFR0;
        `DMR_OFF_MMFR1: rdata_d = `DMR_VAL_MMFR1;
        `DMR_OFF_MMFR2: rdata_d = `DMR_VAL_MMFR2;
        `DMR_OFF_MMFR3: rdata_d = `DMR_VAL_MMFR3;
        `DMR_OFF_ISAR0: rdata_d = `DMR_VAL_ISAR0;
        `DMR_OFF_ISAR1: rdata_d = `DMR_VAL_ISAR1;
        `DMR_OFF_ISAR2: rdata_d = `DMR_VAL_ISAR2;
        `DMR_OFF_ISAR3: rdata_d = `DMR_VAL_ISAR3;
        `DMR_OFF_ISAR4: rdata_d = `DMR_VAL_ISAR4;
        `DMR_OFF_ITCTRL: rdata_d[0] = itctrl_q;
        `DMR_OFF_CLAIM_SET: rdata_d = `DMR_VAL_CLAIM_SET_RD;
        `DMR_OFF_CLAIM_CLR: rdata_d[CLAIM_W-1:0] = claim_q;
        `DMR_OFF_LOCK_STATE: begin
          rdata_d[`DMR_LSR_LOCKED_BIT] = locked_q;
          rdata_d[`DMR_LSR_IMPL_BIT] = 1'b1;
        end
        `DMR_OFF_AUTH: rdata_d = core_info.auth_state;
        `DMR_OFF_UNIT_ID: rdata_d = core_info.unit_id;
        `DMR_OFF_UNIT_TYPE: rdata_d = core_info.unit_type;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
    end else if (rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign rsp.rdata = rdata_q;

  // one access of one register or of one address span, taken at one edge
  sequence seq_rd(logic [11:0] a);
    rd && req.addr == a;
  endsequence
  sequence seq_wr(logic [11:0] a);
    wr && req.addr == a;
  endsequence
  sequence seq_rd_span(logic [11:0] lo, logic [11:0] hi);
    rd && req.addr >= lo && req.addr <= hi;
  endsequence
  sequence seq_key_ok;
    seq_wr(`DMR_OFF_LOCK_KEY) ##0 req.wdata == `DMR_VAL_UNLOCK_KEY;
  endsequence
  sequence seq_key_bad;
    seq_wr(`DMR_OFF_LOCK_KEY) ##0 req.wdata != `DMR_VAL_UNLOCK_KEY;
  endsequence

  AST_PRSR_CONST: assert property (@(posedge clk) disable iff (sys_rst)
    rd && req.addr == `DMR_OFF_PRSR |=> rsp.rdata[31:4] == 28'h0000000 && rsp.rdata[1:0] == 2'h1)
    else $error("status fixed bits wrong");
  AST_PWRUP: assert property (@(posedge clk) disable iff (sys_rst)
    rd && req.addr == `DMR_OFF_PRSR |=> rsp.rdata[0])
    else $error("powered-up bit not one");
  AST_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
    reset_s2_q |=> sticky_reset_q)
    else $error("sticky reset lost");
  AST_STICKY_CLR: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_PRSR) ##0 !reset_s2_q |=> !sticky_reset_q)
    else $error("sticky reset not cleared by read");
  AST_STICKY_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    sticky_reset_q && !(rd && req.addr == `DMR_OFF_PRSR) |=> sticky_reset_q)
    else $error("sticky reset dropped without read");
  AST_LIVE_RESET: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_PRSR) |=> rsp.rdata[`DMR_PRSR_RESET_BIT] == $past(reset_s2_q))
    else $error("live reset bit wrong");
  AST_SPD_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_PRSR) |=> !rsp.rdata[`DMR_PRSR_SPD_BIT])
    else $error("power-down state reported");
  AST_PRSR_WR: assert property (@(posedge clk) disable iff (sys_rst)
    seq_wr(`DMR_OFF_PRSR) ##0 !reset_s2_q |=> sticky_reset_q == $past(sticky_reset_q))
    else $error("status write changed state");

  AST_CACHE: assert property (@(posedge clk) disable iff (sys_rst)
    rd && req.addr == `DMR_OFF_CACHE_TYPE |=> rsp.rdata == 32'h83338003)
    else $error("cache type wrong");
  AST_ALIAS: assert property (@(posedge clk) disable iff (sys_rst)
    rd && req.addr == `DMR_OFF_MAIN_ALIAS1 |=> rsp.rdata == $past(core_info.main_id))
    else $error("main id alias wrong");
  AST_HOLE: assert property (@(posedge clk) disable iff (sys_rst)
    rd && (req.addr == `DMR_OFF_HOLE_D08 || req.addr == `DMR_OFF_AFR0) |=> rsp.rdata == 32'h0)
    else $error("hole not zero");
  AST_MAIN_ID: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MAIN_ID) |=> rsp.rdata == $past(core_info.main_id))
    else $error("main id wrong");
  AST_TLB: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_TLB_TYPE) |=> rsp.rdata == 32'h00000000)
    else $error("tlb type not zero");
  AST_HOLE_D10: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_HOLE_D10) |=> rsp.rdata == 32'h00000000)
    else $error("hole after tlb type not zero");
  AST_MP_AFF: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MP_AFF) |=> rsp.rdata == $past(core_info.mp_affinity))
    else $error("affinity wrong");
  AST_ALIAS0: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MAIN_ALIAS0) |=> rsp.rdata == $past(core_info.main_id))
    else $error("first main id alias wrong");
  AST_PFR0: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_PFR0) |=> rsp.rdata == 32'h00001231)
    else $error("processor feature 0 wrong");
  AST_PFR1: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_PFR1) |=> rsp.rdata == 32'h00000011)
    else $error("processor feature 1 wrong");
  AST_DFR0: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_DFR0) |=> rsp.rdata == 32'h02010444)
    else $error("debug feature wrong");
  AST_AFR0: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_AFR0) |=> rsp.rdata == 32'h00000000)
    else $error("auxiliary feature not zero");
  AST_MMFR0: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MMFR0) |=> rsp.rdata == 32'h00100103)
    else $error("memory model feature 0 wrong");
  AST_MMFR1: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MMFR1) |=> rsp.rdata == 32'h40000000)
    else $error("memory model feature 1 wrong");
  AST_MMFR2: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MMFR2) |=> rsp.rdata == 32'h01230000)
    else $error("memory model feature 2 wrong");
  AST_MMFR3: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_MMFR3) |=> rsp.rdata == 32'h00102211)
    else $error("memory model feature 3 wrong");
  AST_ISAR0: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ISAR0) |=> rsp.rdata == 32'h00101111)
    else $error("instruction set attribute 0 wrong");
  AST_ISAR1: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ISAR1) |=> rsp.rdata == 32'h13112111)
    else $error("instruction set attribute 1 wrong");
  AST_ISAR2: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ISAR2) |=> rsp.rdata == 32'h21232041)
    else $error("instruction set attribute 2 wrong");
  AST_ISAR3: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ISAR3) |=> rsp.rdata == 32'h11112131)
    else $error("instruction set attribute 3 wrong");
  AST_ISAR4: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ISAR4) |=> rsp.rdata == 32'h00011142)
    else $error("instruction set attribute 4 wrong");
  AST_ISAR5: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ISAR5) |=> rsp.rdata == 32'h00000000)
    else $error("instruction set attribute 5 not zero");

  AST_CLAIMSET_RD: assert property (@(posedge clk) disable iff (sys_rst)
    rd && req.addr == `DMR_OFF_CLAIM_SET |=> rsp.rdata == 32'h000000ff)
    else $error("claim set read wrong");
  AST_LOCKED_WR: assert property (@(posedge clk) disable iff (sys_rst)
    locked_q && !(wr && req.addr == `DMR_OFF_LOCK_KEY) |=> $stable(claim_q) && $stable(itctrl_q))
    else $error("write passed lock");
  AST_UNLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    wr && req.addr == `DMR_OFF_LOCK_KEY && req.wdata == 32'hc5acce55 |=> !locked_q)
    else $error("key did not unlock");
  AST_ITCTRL_WR: assert property (@(posedge clk) disable iff (sys_rst)
    seq_wr(`DMR_OFF_ITCTRL) ##0 !locked_q |=> itctrl_q == $past(req.wdata[0]))
    else $error("integration control write lost");
  AST_ITCTRL_RD: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_ITCTRL) |=> rsp.rdata == {31'h0, $past(itctrl_q)})
    else $error("integration control read wrong");
  AST_RSV_F: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd_span(`DMR_OFF_RSV_LO, `DMR_OFF_RSV_HI) |=> rsp.rdata == 32'h00000000)
    else $error("reserved management slot not zero");
  AST_CLAIM_SET_WR: assert property (@(posedge clk) disable iff (sys_rst)
    seq_wr(`DMR_OFF_CLAIM_SET) ##0 !locked_q
      |=> claim_q == ($past(claim_q) | $past(req.wdata[CLAIM_W-1:0])))
    else $error("claim set write wrong");
  AST_CLAIM_CLR_WR: assert property (@(posedge clk) disable iff (sys_rst)
    seq_wr(`DMR_OFF_CLAIM_CLR) ##0 !locked_q
      |=> claim_q == ($past(claim_q) & ~$past(req.wdata[CLAIM_W-1:0])))
    else $error("claim clear write wrong");
  AST_CLAIM_RD: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_CLAIM_CLR) |=> rsp.rdata == 32'($past(claim_q)))
    else $error("claim state read wrong");
  AST_LOCK_KEY_RD: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_LOCK_KEY) |=> rsp.rdata == 32'h00000000)
    else $error("lock key readable");
  AST_LOCK_STATE: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_LOCK_STATE) |=> rsp.rdata == {30'h0, $past(locked_q), 1'b1})
    else $error("lock state read wrong");
  AST_KEY_OTHER: assert property (@(posedge clk) disable iff (sys_rst)
    seq_key_bad |=> locked_q)
    else $error("other value did not lock");
  AST_UNLOCK_SEEN: assert property (@(posedge clk) disable iff (sys_rst)
    seq_key_ok ##1 !(wr && req.addr == `DMR_OFF_LOCK_KEY)
      ##1 seq_rd(`DMR_OFF_LOCK_STATE) |=> rsp.rdata == 32'h00000001)
    else $error("lock state not clear after key");
  AST_RELOCK_SEEN: assert property (@(posedge clk) disable iff (sys_rst)
    seq_key_bad ##1 !(wr && req.addr == `DMR_OFF_LOCK_KEY)
      ##1 seq_rd(`DMR_OFF_LOCK_STATE) |=> rsp.rdata == 32'h00000003)
    else $error("lock state not set after other value");
  AST_AUTH: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_AUTH) |=> rsp.rdata == $past(core_info.auth_state))
    else $error("authentication state wrong");
  AST_RSV_FBC: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd_span(`DMR_OFF_RSV2_LO, `DMR_OFF_RSV2_HI) |=> rsp.rdata == 32'h00000000)
    else $error("slot before unit identifier not zero");
  AST_UNIT_ID: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_UNIT_ID) |=> rsp.rdata == $past(core_info.unit_id))
    else $error("unit identifier wrong");
  AST_UNIT_TYPE: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_UNIT_TYPE) |=> rsp.rdata == $past(core_info.unit_type))
    else $error("unit type wrong");
  AST_IDENT_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_IDENT_LO) |=> rsp.rdata == $past(ident_regs[31:0]))
    else $error("first identification word wrong");
  AST_IDENT_LAST: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd(`DMR_OFF_IDENT_HI) |=> rsp.rdata == $past(ident_regs[383:352]))
    else $error("last identification word wrong");
  AST_RAZ_E: assert property (@(posedge clk) disable iff (sys_rst)
    seq_rd_span(`DMR_OFF_RAZ_E_LO, `DMR_OFF_RAZ_E_HI) |=> rsp.rdata == 32'h00000000)
    else $error("unused range not zero");
  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !rd |=> $stable(rsp.rdata))
    else $error("read data moved without a read");
endmodule

// ==== dmr_regs_tb.sv ====
`timescale 1ns/1ps
module dmr_regs_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  dmr_pkg::dmr_req_t req;
  dmr_pkg::dmr_rsp_t rsp;
  dmr_pkg::dmr_core_info_t core_info;
  logic [383:0] ident_regs;
  logic core_in_reset = 1'b0;
  logic integration_mode;
  logic [31:0] got;
  int bad_count = 0;
  int compares = 0;
  logic [11:0] fa [0:22];
  logic [31:0] fv [0:22];
  always #2.5 clk = ~clk;
  dmr_regs dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(req),
    .rsp(rsp),
    .core_info(core_info),
    .ident_regs(ident_regs),
    .core_in_reset(core_in_reset),
    .integration_mode(integration_mode)
  );
  dmr_dbg_model dbg (.clk(clk), .req(req), .rsp(rsp));
  task automatic stop_test;
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    dbg.rd(a, got);
    check(got, e, $sformatf("read %h", a));
  endtask
  initial begin
    #20000;
    bad_count++;
    stop_test;
  end
  initial begin
    // core values are arbitrary
    core_info = '{32'h1234abcd, 32'h00000a01, 32'h000000aa, 32'h00000015, 32'h00000c14};
    for (int k = 0; k < 12; k++) begin
      ident_regs[32*k +: 32] = 32'h5a000000 + k;
    end
    fa = '{12'hd04, 12'hd08, 12'hd0c, 12'hd10, 12'hd20, 12'hd24, 12'hd28, 12'hd2c,
           12'hd30, 12'hd34, 12'hd38, 12'hd3c, 12'hd40, 12'hd44, 12'hd48, 12'hd4c,
           12'hd50, 12'hd54, 12'he00, 12'hf04, 12'hf9c, 12'hfbc, 12'hfc4};
    fv = '{32'h83338003, 32'h0, 32'h0, 32'h0, 32'h00001231, 32'h00000011, 32'h02010444,
           32'h0, 32'h00100103, 32'h40000000, 32'h01230000, 32'h00102211, 32'h00101111,
           32'h13112111, 32'h21232041, 32'h11112131, 32'h00011142, 32'h0, 32'h0, 32'h0,
           32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rdchk(12'h314, 32'h00000001);
    rdchk(12'hfb4, 32'h00000003);
    dbg.wr(12'hf00, 32'h00000001);
    rdchk(12'hf00, 32'h00000000);
    dbg.wr(12'hfb0, 32'hc5acce55);
    rdchk(12'hfb4, 32'h00000001);
    dbg.wr(12'hf00, 32'h00000001);
    rdchk(12'hf00, 32'h00000001);
    check({31'h0, integration_mode}, 32'h00000001, "integration mode");
    dbg.wr(12'hfa0, 32'h00000008);
    dbg.wr(12'hfa0, 32'h00000000);
    rdchk(12'hfa4, 32'h00000008);
    rdchk(12'hfa0, 32'h000000ff);
    dbg.wr(12'hfa4, 32'h00000008);
    rdchk(12'hfa4, 32'h00000000);
    // read-only places and holes must drop writes
    dbg.wr(12'hd04, 32'h00000000);
    dbg.wr(12'hd08, 32'hffffffff);
    dbg.wr(12'hfb8, 32'h00000000);
    dbg.wr(12'hfd0, 32'h00000000);
    dbg.wr(12'h314, 32'hfffffff0);
    rdchk(12'h314, 32'h00000001);
    for (int i = 0; i < 23; i++) begin
      rdchk(fa[i], fv[i]);
    end
    rdchk(12'hd00, core_info.main_id);
    rdchk(12'hd14, core_info.mp_affinity);
    rdchk(12'hd18, core_info.main_id);
    rdchk(12'hd1c, core_info.main_id);
    rdchk(12'hfb8, core_info.auth_state);
    rdchk(12'hfc8, core_info.unit_id);
    rdchk(12'hfcc, core_info.unit_type);
    rdchk(12'hfd0, ident_regs[31:0]);
    rdchk(12'hfe0, ident_regs[159:128]);
    rdchk(12'hffc, ident_regs[383:352]);
    rdchk(12'hfb0, 32'h00000000);
    core_in_reset = 1'b1;
    repeat (4) @(posedge clk);
    rdchk(12'h314, 32'h0000000d);
    core_in_reset = 1'b0;
    repeat (4) @(posedge clk);
    rdchk(12'h314, 32'h00000009);
    rdchk(12'h314, 32'h00000001);
    dbg.wr(12'hfb0, 32'h00000000);
    rdchk(12'hfb4, 32'h00000003);
    dbg.wr(12'hf00, 32'h00000000);
    rdchk(12'hf00, 32'h00000001);
    check({31'h0, integration_mode}, 32'h00000001, "integration mode held");
    stop_test;
  end
endmodule
